// ### mmt_pkg.sv
// Constants and types shared by the translation buffer control block
package mmt_pkg;
	// ----------------------------------------------------------------
	// Register window
	// ----------------------------------------------------------------
	localparam logic [31:0] MMT_BASE = 32'hf7e1_8000;
	localparam int WIN_BITS = 8;
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_TAG = 8'h04;
	localparam logic [7:0] OFS_TVA = 8'h0c;
	localparam logic [7:0] OFS_TPA = 8'h10;
	localparam logic [7:0] OFS_TPX = 8'h14;
	localparam logic [7:0] OFS_TFA = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_MODE = 0;
	localparam int POS_SIZE_A = 1;
	localparam int POS_SIZE_B = 3;
	localparam int POS_CNT = 5;
	localparam int TAG_W = 5;
	localparam int ATTR_LSB = 24;
	localparam int PAGE_SHIFT_BASE = 10;
	localparam int BANK_B_BASE = 128;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] RST_TAG = 5'h00;
	localparam logic [31:0] RST_RESULT = 32'h0000_0000;
	localparam logic [4:0] RST_CFG = 5'h00;

	// ----------------------------------------------------------------
	// Trap identification
	// ----------------------------------------------------------------
	localparam logic [7:0] TRAP_ID_FILL = 8'h00;
	localparam logic [7:0] TRAP_ID_PROT = 8'h01;

	typedef enum logic [5:0] {
		CMD_MAP = 6'h01,
		CMD_DEMAP = 6'h02,
		CMD_FLUSH_A = 6'h04,
		CMD_FLUSH_B = 6'h08,
		CMD_PROBE_A = 6'h10,
		CMD_PROBE_I = 6'h20
	} mmt_cmd_t;

	typedef enum logic [2:0] {
		ACC_FETCH = 3'h1,
		ACC_LOAD = 3'h2,
		ACC_STORE = 3'h4
	} mmt_acc_t;
endpackage

// ### mmt_tlb.sv
// Two-bank translation buffer: commands, lookup, traps and registers
//
// Overview of operation
// - Install with unmatched page size does nothing
// - Equal bank sizes: install into one bank
// - Pages a, a+1, b, b+1..63 coexist
// - Uninstall matches operand address and space tag
// - Uninstall without resident entry does nothing
// - Two flush variants clear bank A or B
// - Address probe searches with current space tag
// - Index probe reads entry at given index
// - Probe loads virtual, physical and index results
// - Invalid entry or index clears physical valid
// - Only configuration and space tag are writable
// - Registers decode in 256-byte base window
// - Configuration bit 0 selects virtual mode
// - Bits [2:1],[4:3] set bank page sizes
// - Bits [11:5] report read-only entry count minus one
// - Space tag in [4:0], reset zero
// - Virtual result: page [23:0], tag [28:24]
// - Physical result: page, size, six attributes
// - Index result in [7:0], upper zero
// - Fault register holds shifted faulting address
// - Valid, page match, tag match or global
// - Miss gives fill trap, denial protection trap
// - Install operand: page low 24, attributes high
module mmt_tlb import mmt_pkg::*; #(
	parameter int ENTRIES = 8
) (
	// Clock and reset
	input logic clock,
	input logic rst,
	// Core register access
	input logic reg_rd,
	input logic reg_wr,
	input logic [31:0] reg_addr,
	input logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	// Buffer commands
	input logic cmd_valid,
	input mmt_cmd_t cmd_op,
	input logic [31:0] cmd_even,
	input logic [31:0] cmd_odd,
	output logic cmd_done,
	// Translation requests
	input logic xl_valid,
	input mmt_acc_t xl_acc,
	input logic [31:0] xl_vaddr,
	output logic xl_done,
	output logic xl_hit,
	output logic [23:0] xl_phys_page,
	output logic xl_cacheable,
	output logic fill_trap,
	output logic protection_trap,
	output logic [7:0] trap_identification,
	// Mode
	output logic virtual_mode
);
	localparam int IW = $clog2(ENTRIES);
	localparam int NH = 2 * ENTRIES;
	localparam logic [6:0] ENTRY_COUNT = 7'(ENTRIES - 1);

	if (ENTRIES < 4 || ENTRIES > 128) begin : g_bad_entries
		$error("ENTRIES must lie in 4..128");
	end

	typedef struct packed {
		logic v;
		logic fetch_permit;
		logic store_permit;
		logic load_permit;
		logic g;
		logic c;
		logic [TAG_W-1:0] space_tag;
		logic [23:0] virtual_page_number;
		logic [23:0] physical_page_number;
	} mmt_entry_t;

	typedef struct packed {
		mmt_entry_t [1:0][ENTRIES-1:0] ent;
		logic [1:0][IW-1:0] ptr;
		logic mode;
		logic [1:0][1:0] sz;
		logic [TAG_W-1:0] tag;
		logic [31:0] tva;
		logic [31:0] tpa;
		logic [31:0] tpx;
		logic [31:0] tfa;
		logic [31:0] rdata;
		logic ack;
		logic cdone;
		logic xdone;
		logic xhit;
		logic [23:0] xppn;
		logic xc;
		logic ftrap;
		logic ptrap;
		logic [7:0] trap_id;
	} mmt_state_t;

	mmt_state_t q_q, q_d;

	function automatic logic [23:0] page_of(input logic [31:0] a, input logic [1:0] s);
		logic [31:0] t;
		t = a >> (PAGE_SHIFT_BASE + 2 * int'(s));
		return t[23:0];
	endfunction

	function automatic logic [7:0] first_idx(input logic [NH-1:0] h);
		logic [7:0] r;
		r = '0;
		for (int k = NH - 1; k >= 0; k--) begin
			if (h[k]) begin
				r = (k >= ENTRIES) ? 8'(BANK_B_BASE + k - ENTRIES) : 8'(k);
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Entry match
	// ----------------------------------------------------------------
	logic [NH-1:0] hit_x, hit_c, v_vec;

	for (genvar b = 0; b < 2; b++) begin : g_bank
		for (genvar e = 0; e < ENTRIES; e++) begin : g_ent
			mmt_entry_t en;
			assign en = q_q.ent[b][e];
			assign v_vec[b*ENTRIES+e] = en.v;
			assign hit_x[b*ENTRIES+e] = en.v
				&& en.virtual_page_number == page_of(xl_vaddr, q_q.sz[b])
				&& (en.g || en.space_tag == q_q.tag);
			assign hit_c[b*ENTRIES+e] = en.v
				&& en.virtual_page_number == page_of(cmd_even, q_q.sz[b])
				&& (en.g || en.space_tag == q_q.tag);
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic in_win;
	logic [7:0] ofs;
	logic [1:0] map_sz, min_sz;
	logic [7:0] pidx, xidx;
	logic pok, bk, permit;
	logic [23:0] fva;
	mmt_entry_t pe, xent;

	assign in_win = reg_addr[31:WIN_BITS] == MMT_BASE[31:WIN_BITS];
	assign ofs = reg_addr[WIN_BITS-1:0];
	assign map_sz = cmd_odd[ATTR_LSB+:2];
	assign min_sz = (q_q.sz[0] < q_q.sz[1]) ? q_q.sz[0] : q_q.sz[1];
	assign fva = page_of(xl_vaddr, min_sz);

	always_comb begin
		q_d = q_q;
		q_d.ack = 1'b0;
		q_d.cdone = 1'b0;
		q_d.xdone = 1'b0;
		q_d.ftrap = 1'b0;
		q_d.ptrap = 1'b0;
		bk = 1'b0;
		permit = 1'b0;
		pidx = (cmd_op == CMD_PROBE_A) ? first_idx(hit_c) : cmd_even[7:0];
		pok = (cmd_op == CMD_PROBE_A) ? |hit_c : (32'(cmd_even[6:0]) < ENTRIES);
		pe = q_q.ent[pidx[7]][pidx[IW-1:0]];
		xidx = first_idx(hit_x);
		xent = q_q.ent[xidx[7]][xidx[IW-1:0]];

		// Register port
		if (reg_rd && in_win) begin
			q_d.ack = 1'b1;
			unique case (ofs)
				OFS_CFG: q_d.rdata = {20'h0, ENTRY_COUNT, q_q.sz[1], q_q.sz[0], q_q.mode};
				OFS_TAG: q_d.rdata = {27'h0, q_q.tag};
				OFS_TVA: q_d.rdata = q_q.tva;
				OFS_TPA: q_d.rdata = q_q.tpa;
				OFS_TPX: q_d.rdata = q_q.tpx;
				OFS_TFA: q_d.rdata = q_q.tfa;
				default: q_d.rdata = '0;
			endcase
		end else if (reg_wr && in_win) begin
			q_d.ack = 1'b1;
			if (ofs == OFS_CFG) begin
				q_d.mode = reg_wdata[POS_MODE];
				q_d.sz[0] = reg_wdata[POS_SIZE_A+:2];
				q_d.sz[1] = reg_wdata[POS_SIZE_B+:2];
			end else if (ofs == OFS_TAG) begin
				q_d.tag = reg_wdata[TAG_W-1:0];
			end
		end

		// Commands
		if (cmd_valid) begin
			q_d.cdone = 1'b1;
			unique case (cmd_op)
				CMD_MAP: begin
					if (map_sz == q_q.sz[0] || map_sz == q_q.sz[1]) begin
						bk = (map_sz != q_q.sz[0]);
						q_d.ent[bk][q_q.ptr[bk]] = '{
							v: cmd_odd[31],
							fetch_permit: cmd_odd[30],
							store_permit: cmd_odd[29],
							load_permit: cmd_odd[28],
							g: cmd_odd[27],
							c: cmd_odd[26],
							space_tag: q_q.tag,
							virtual_page_number: page_of(cmd_even, map_sz),
							physical_page_number: cmd_odd[23:0]};
						// Round robin keeps the last ENTRIES installs of each bank resident
						q_d.ptr[bk] = (32'(q_q.ptr[bk]) == ENTRIES - 1) ? '0 : q_q.ptr[bk] + 1'b1;
					end
				end
				CMD_DEMAP: begin
					for (int k = 0; k < NH; k++) begin
						if (hit_c[k]) begin
							q_d.ent[k / ENTRIES][k % ENTRIES].v = 1'b0;
						end
					end
				end
				CMD_FLUSH_A: begin
					for (int k = 0; k < ENTRIES; k++) begin
						q_d.ent[0][k].v = 1'b0;
					end
				end
				CMD_FLUSH_B: begin
					for (int k = 0; k < ENTRIES; k++) begin
						q_d.ent[1][k].v = 1'b0;
					end
				end
				CMD_PROBE_A, CMD_PROBE_I: begin
					q_d.tpx = {24'h0, pidx};
					if (pok) begin
						q_d.tva = {3'h0, pe.space_tag, pe.virtual_page_number};
						q_d.tpa = {pe.v, pe.fetch_permit, pe.store_permit, pe.load_permit,
							pe.g, pe.c, q_q.sz[pidx[7]], pe.physical_page_number};
					end else begin
						q_d.tva = '0;
						q_d.tpa = '0;
					end
				end
			endcase
		end

		// Translation and traps
		if (xl_valid) begin
			q_d.xdone = 1'b1;
			unique case (xl_acc)
				ACC_FETCH: permit = xent.fetch_permit;
				ACC_LOAD: permit = xent.load_permit;
				ACC_STORE: permit = xent.store_permit;
			endcase
			q_d.xhit = |hit_x && permit;
			q_d.xppn = xent.physical_page_number;
			q_d.xc = xent.c;
			if (!(|hit_x)) begin
				q_d.ftrap = 1'b1;
				q_d.trap_id = TRAP_ID_FILL;
				q_d.tfa = {8'h0, fva};
			end else if (!permit) begin
				q_d.ptrap = 1'b1;
				q_d.trap_id = TRAP_ID_PROT;
				q_d.tfa = {8'h0, fva};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q_q <= '0;
			q_q.tag <= RST_TAG;
			q_q.tpa <= RST_RESULT;
			{q_q.sz, q_q.mode} <= RST_CFG;
		end else begin
			q_q <= q_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = q_q.rdata;
	assign reg_ack = q_q.ack;
	assign cmd_done = q_q.cdone;
	assign xl_done = q_q.xdone;
	assign xl_hit = q_q.xhit;
	assign xl_phys_page = q_q.xppn;
	assign xl_cacheable = q_q.xc;
	assign fill_trap = q_q.ftrap;
	assign protection_trap = q_q.ptrap;
	assign trap_identification = q_q.trap_id;
	assign virtual_mode = q_q.mode;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	flush_bank_a: assert property (cmd_valid && cmd_op == CMD_FLUSH_A
		|=> v_vec[ENTRIES-1:0] == '0) else $error("bank A not flushed");
	map_nop_a: assert property (cmd_valid && cmd_op == CMD_MAP
		&& map_sz != q_q.sz[0] && map_sz != q_q.sz[1] |=> $stable(q_q.ent))
		else $error("unmatched install changed entries");
	map_single_a: assert property (cmd_valid && cmd_op == CMD_MAP
		&& map_sz == q_q.sz[0] && map_sz == q_q.sz[1] |=> $stable(q_q.ent[1]))
		else $error("install touched both banks");
	demap_hit_a: assert property (cmd_valid && cmd_op == CMD_DEMAP
		|=> (v_vec & $past(hit_c)) == '0) else $error("uninstall left entry valid");
	probe_index_a: assert property (cmd_valid && cmd_op == CMD_PROBE_I
		&& 32'(cmd_even[6:0]) >= ENTRIES |=> !q_q.tpa[31] && q_q.tpx[7:0] == $past(cmd_even[7:0]))
		else $error("bad index probe left valid set");
	tag_write_a: assert property (reg_wr && !reg_rd && in_win && ofs == OFS_TAG
		|=> q_q.tag == $past(reg_wdata[4:0]) && reg_ack)
		else $error("space tag not written");
	ro_result_a: assert property (reg_wr && !reg_rd && in_win && ofs != OFS_CFG
		&& ofs != OFS_TAG && !cmd_valid && !xl_valid
		|=> $stable(q_q.tva) && $stable(q_q.tpa) && $stable(q_q.tpx) && $stable(q_q.tfa)
		&& $stable(q_q.mode) && $stable(q_q.sz) && $stable(q_q.tag))
		else $error("read-only register changed");
	fill_trap_a: assert property (xl_valid && !(|hit_x)
		|=> fill_trap && !protection_trap && trap_identification == TRAP_ID_FILL
		&& q_q.tfa == {8'h0, $past(fva)}) else $error("fill trap wrong");
	mode_write_a: assert property (reg_wr && !reg_rd && in_win && ofs == OFS_CFG
		|=> virtual_mode == $past(reg_wdata[0]) && reg_ack) else $error("mode bit not written");
endmodule // mmt_tlb

// ### mmt_core.sv
// Core model that issues register, command and translation requests
module mmt_core import mmt_pkg::*; (
	// Clock
	input logic clock,
	// Register bus
	output logic reg_rd,
	output logic reg_wr,
	output logic [31:0] reg_addr,
	output logic [31:0] reg_wdata,
	input logic [31:0] reg_rdata,
	input logic reg_ack,
	// Commands
	output logic cmd_valid,
	output mmt_cmd_t cmd_op,
	output logic [31:0] cmd_even,
	output logic [31:0] cmd_odd,
	input logic cmd_done,
	// Translation
	output logic xl_valid,
	output mmt_acc_t xl_acc,
	output logic [31:0] xl_vaddr,
	input logic xl_done
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{reg_rd, reg_wr, cmd_valid, xl_valid} = 4'h0;
		{reg_addr, reg_wdata, cmd_even, cmd_odd, xl_vaddr} = '0;
		cmd_op = CMD_PROBE_A;
		xl_acc = ACC_LOAD;
	end

	// Released address and data lines show the inverse so stale values never pass
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic k);
		@(negedge clock);
		reg_rd = !w;
		reg_wr = w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		{reg_rd, reg_wr} = 2'h0;
		q = reg_rdata;
		k = reg_ack;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic cmd(input mmt_cmd_t op, input logic [31:0] e, input logic [31:0] o,
		output logic k);
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_even = e;
		cmd_odd = o;
		@(negedge clock);
		cmd_valid = 1'b0;
		k = cmd_done;
		cmd_even = ~e;
		cmd_odd = ~o;
	endtask

	task automatic xl(input mmt_acc_t a, input logic [31:0] v, output logic k);
		@(negedge clock);
		xl_valid = 1'b1;
		xl_acc = a;
		xl_vaddr = v;
		@(negedge clock);
		xl_valid = 1'b0;
		k = xl_done;
		xl_vaddr = ~v;
	endtask
endmodule // mmt_core

// ### mmt_tlb_test.sv
// Self-checking bench for the translation buffer control block
module mmt_tlb_test import mmt_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = 8;
	logic clock = 0, rst = 1, reg_rd, reg_wr, reg_ack, cmd_valid, cmd_done, xl_valid, xl_done;
	logic xl_hit, xl_cacheable, fill_trap, protection_trap, virtual_mode, k;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, cmd_even, cmd_odd, xl_vaddr, q;
	logic [23:0] xl_phys_page;
	logic [7:0] trap_identification;
	mmt_cmd_t cmd_op;
	mmt_acc_t xl_acc;
	int miscompares = 0, total_checks = 0, cycles = 0;

	mmt_tlb #(.ENTRIES(N)) DUT (
		.clock(clock), .rst(rst),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_even(cmd_even), .cmd_odd(cmd_odd),
		.cmd_done(cmd_done),
		.xl_valid(xl_valid), .xl_acc(xl_acc), .xl_vaddr(xl_vaddr), .xl_done(xl_done),
		.xl_hit(xl_hit), .xl_phys_page(xl_phys_page), .xl_cacheable(xl_cacheable),
		.fill_trap(fill_trap), .protection_trap(protection_trap),
		.trap_identification(trap_identification), .virtual_mode(virtual_mode)
	);
	mmt_core core (
		.clock(clock),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_even(cmd_even), .cmd_odd(cmd_odd),
		.cmd_done(cmd_done),
		.xl_valid(xl_valid), .xl_acc(xl_acc), .xl_vaddr(xl_vaddr), .xl_done(xl_done)
	);

	always #25 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (miscompares == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rd(logic [7:0] o, logic [31:0] e, logic [31:0] m = '1);
		core.acc(1'b0, MMT_BASE + {24'h0, o}, '0, q, k);
		chk("ack", 32'h1, {31'h0, k});
		chk($sformatf("reg %h", o), e, q & m);
	endtask

	task automatic wr(logic [7:0] o, logic [31:0] d);
		core.acc(1'b1, MMT_BASE + {24'h0, o}, d, q, k);
	endtask

	task automatic cm(mmt_cmd_t op, logic [31:0] e, logic [31:0] o = '0);
		core.cmd(op, e, o, k);
		chk("done", 32'h1, {31'h0, k});
	endtask

	task automatic probe(logic [31:0] va, logic [31:0] tva, logic [31:0] tpa);
		cm(CMD_PROBE_A, va);
		rd(OFS_TVA, tva);
		rd(OFS_TPA, tpa);
	endtask

	task automatic tx(mmt_acc_t a, logic [31:0] va, logic [2:0] hfp, logic [23:0] phys);
		core.xl(a, va, k);
		chk("xl", {28'h1, hfp}, {27'h0, k, xl_hit, fill_trap, protection_trap});
		if (hfp[2]) chk("phys page", {8'h0, phys}, {8'h0, xl_phys_page});
		if (hfp[2]) chk("cacheable", 32'h1, {31'h0, xl_cacheable});
		if (hfp[1:0] != 0) chk("trap id", {31'h0, hfp[0]}, {24'h0, trap_identification});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] ofs [7] = '{OFS_TAG, OFS_TVA, OFS_TPA, OFS_TPX, OFS_TFA, 8'h08, 8'hfc};
		rd(OFS_CFG, {20'h0, 7'(N - 1), 5'h0});
		foreach (ofs[i]) rd(ofs[i], '0);
		wr(OFS_TPA, '1);
		wr(OFS_TFA, '1);
		rd(OFS_TPA, '0);
		rd(OFS_TFA, '0);
		core.acc(1'b0, MMT_BASE - 4, '0, q, k);
		chk("ack low", '0, {31'h0, k});
		core.acc(1'b0, MMT_BASE + 32'h100, '0, q, k);
		chk("ack high", '0, {31'h0, k});
	endtask

	task automatic t_cfg();
		wr(OFS_CFG, '1);
		rd(OFS_CFG, {20'h0, 7'(N - 1), 5'h1f});
		chk("mode", 32'h1, {31'h0, virtual_mode});
		wr(OFS_CFG, 32'h8);
		rd(OFS_CFG, {20'h0, 7'(N - 1), 5'h08});
		chk("mode", 32'h0, {31'h0, virtual_mode});
		wr(OFS_TAG, '1);
		rd(OFS_TAG, 32'h1f);
		wr(OFS_TAG, 32'h3);
	endtask

	task automatic t_cmds();
		cm(CMD_MAP, 32'h0001_2c00, 32'hb400_0123);
		probe(32'h0001_2c00, 32'h0300_004b, 32'hb400_0123);
		cm(CMD_PROBE_I, 32'h80);
		rd(OFS_TPA, '0, 32'h8000_0000);
		rd(OFS_TPX, 32'h80);
		cm(CMD_PROBE_I, 32'h7f);
		rd(OFS_TPA, '0, 32'h8000_0000);
		rd(OFS_TPX, 32'h7f);
		tx(ACC_LOAD, 32'h0001_2fff, 3'h4, 24'h123);
		tx(ACC_FETCH, 32'h0001_2c00, 3'h1, '0);
		wr(OFS_TAG, 32'h4);
		tx(ACC_LOAD, 32'h0001_2c00, 3'h2, '0);
		rd(OFS_TFA, 32'h4b);
		wr(OFS_TAG, 32'h3);
		cm(CMD_MAP, 32'h0004_0000, 32'hb600_0200);
		probe(32'h0004_0000, '0, '0);
		cm(CMD_MAP, 32'h0008_0000, 32'hb500_0300);
		probe(32'h0008_0000, 32'h0300_0080, 32'hb500_0300);
		rd(OFS_TPX, 32'h80);
		cm(CMD_FLUSH_B, '0);
		probe(32'h0008_0000, '0, '0);
		probe(32'h0001_2c00, 32'h0300_004b, 32'hb400_0123);
		cm(CMD_DEMAP, 32'h0001_2c00);
		probe(32'h0001_2c00, '0, '0);
		cm(CMD_DEMAP, 32'h0001_2c00);
	endtask

	task automatic t_coexist();
		logic [23:0] pg [4] = '{24'h100, 24'h101, 24'h200, 24'h23f};
		wr(OFS_CFG, '0);
		foreach (pg[i]) cm(CMD_MAP, {pg[i][21:0], 10'h0}, {8'hb4, pg[i]});
		foreach (pg[i]) tx(ACC_LOAD, {pg[i][21:0], 10'h0}, 3'h4, pg[i]);
		tx(ACC_STORE, 32'h0004_0400, 3'h4, 24'h101);
		probe(32'h0004_0000, 32'h0300_0100, 32'hb400_0100);
		rd(OFS_TPX, '0, 32'h80);
		cm(CMD_FLUSH_A, '0);
		tx(ACC_LOAD, 32'h0004_0000, 3'h2, '0);
	endtask

	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		t_regs();
		t_cfg();
		t_cmds();
		t_coexist();
		stop_test();
	end
endmodule // mmt_tlb_test
